//--- rtl/sac_adc_top.sv
`timescale 1ns/10ps
// Conversion control and serial readout
module sac_adc_top #(
  parameter int CONV_CYC = sac_pkg::CONV_CYC_DEF, // Conversion length in cycles
  parameter int INT_DIV  = sac_pkg::INT_DIV_DEF,  // Cycles per internal clock phase
  parameter int DEPTH    = sac_pkg::FIFO_DEPTH    // Result buffer depth
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        selectN,
  input  wire logic        readConvert,
  input  wire logic        powerDownInput,
  input  wire logic        clockSourceSelect,
  input  wire logic        serialShiftClockIn,
  input  wire logic        chainTag,
  input  wire logic [15:0] sampleCode,
  output logic             busyN,
  output logic             serialData,
  output logic             serialShiftClockOut,
  output logic             serialShiftClockOeN,
  output logic             frameMarker
);
  localparam int NB = sac_pkg::RES_BITS;

  // State of the block outside the result buffer
  typedef struct packed {
    logic [sac_pkg::PIN_N-1:0] syncA;    // First synchroniser stage
    logic [sac_pkg::PIN_N-1:0] syncB;    // Second synchroniser stage
    logic                      csPrev;   // Select one cycle ago
    logic                      rcPrev;   // Strobe one cycle ago
    logic                      extPrev;  // External clock one cycle ago
    sac_pkg::sac_conv_type     state;    // Conversion sequencer
    logic                      armQ;     // Start rearmed by release
    logic [1:0]                startCnt; // Start low cycles seen
    logic [15:0]               convCnt;  // Conversion timer
    logic                      busyN;    // Busy output
    logic [NB-1:0]             heldQ;    // Latest latched result
    logic [NB-1:0]             sr;       // Output shift register
    logic                      tagQ;     // Tag at conversion start
    logic                      dataQ;    // Serial data output
    logic                      intClk;   // Internal shift clock
    logic [7:0]                divCnt;   // Rate divider
    logic                      intActive;// Internal readout running
    logic [1:0]                phase;    // Bit phase
    logic [4:0]                bitCnt;   // Bit counter
    logic                      extActive;// External readout running
    logic [4:0]                extCnt;   // External rising edges seen
    logic                      markArm;  // Marker enabled by clock
    logic                      markOn;   // Marker used this read
    logic                      frame;    // Frame marker output
    logic [4:0]                pulseCnt; // Internal pulses this readout
  } sac_top_state_type;

  sac_top_state_type q;
  sac_top_state_type d;

  sac_fifo_if #(.WIDTH(NB)) rbuf ();

  logic [sac_pkg::PIN_N-1:0] pinsRaw; // Raw asynchronous pins
  logic csS;       // Synchronised select
  logic rcS;       // Synchronised strobe
  logic pdS;       // Synchronised power-down
  logic extModeS;  // Synchronised clock source
  logic extClkS;   // Synchronised external clock
  logic tagS;      // Synchronised tag
  logic orLow;     // ORed start term is low
  logic extRise;   // External clock rising
  logic extFall;   // External clock falling
  logic tick;      // Internal rate enable
  logic readStart; // External read begins
  logic popGo;     // Result moves into stored register
  logic [4:0] extLast; // Last edge index of a read

  // Result buffer
  sac_fifo #(
    .WIDTH(NB),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst   (nrst),
    .port   (rbuf.store)
  );

  // Pins gathered for synchronising
  assign pinsRaw = {chainTag, serialShiftClockIn, clockSourceSelect,
                    powerDownInput, readConvert, selectN};
  assign csS      = q.syncB[sac_pkg::PIN_CS];
  assign rcS      = q.syncB[sac_pkg::PIN_RC];
  assign pdS      = q.syncB[sac_pkg::PIN_PD];
  assign extModeS = q.syncB[sac_pkg::PIN_EXT];
  assign extClkS  = q.syncB[sac_pkg::PIN_CLK];
  assign tagS     = q.syncB[sac_pkg::PIN_TAG];

  // Select and strobe ORed: start when both low
  assign orLow   = !(csS || rcS);
  assign extRise = extClkS && !q.extPrev;
  assign extFall = !extClkS && q.extPrev;
  assign tick    = (q.divCnt == 8'(INT_DIV - 1));
  assign extLast = 5'(NB) + {4'h0, q.markOn};

  // Strobe rise with select low, or select fall with strobe high
  assign readStart = extModeS && !q.extActive &&
                     ((rcS && !q.rcPrev && !csS) || (!csS && q.csPrev && rcS));

  // Buffer handshakes
  assign rbuf.inValid  = (q.state == sac_pkg::ST_DONE);
  assign rbuf.inData   = sampleCode;
  assign rbuf.outReady = !q.intActive && !q.extActive; // Never reload mid-shift
  assign popGo         = rbuf.outValid && rbuf.outReady;

  // Outputs
  assign busyN               = q.busyN;
  assign serialData          = q.dataQ;
  assign serialShiftClockOut = q.intClk;
  assign serialShiftClockOeN = extModeS;
  assign frameMarker         = q.frame;

  // Next state
  always_comb begin
    d = q;
    d.syncA   = pinsRaw;
    d.syncB   = q.syncA;
    d.csPrev  = csS;
    d.rcPrev  = rcS;
    d.extPrev = extClkS;

    // Stored result taken from the buffer, untouched otherwise
    if (popGo) begin
      d.heldQ = rbuf.outData;
    end

    // Internal readout: load, rise, fall per bit
    if (q.intActive) begin
      d.divCnt = tick ? 8'h00 : q.divCnt + 8'h01;
      if (tick) begin
        unique case (q.phase)
          2'h0: begin
            if (q.bitCnt == 5'(NB)) begin
              // Tag waits one phase so the LSB still stands at the last fall
              d.intActive = 1'b0;
              d.dataQ     = q.tagQ;
            end else begin
              // New bit while clock is low
              d.dataQ = q.sr[NB-1];
              d.sr    = {q.sr[NB-2:0], q.tagQ};
              d.phase = 2'h1;
            end
          end
          2'h1: begin
            // Rising edge in the middle of the bit
            d.intClk   = 1'b1;
            d.pulseCnt = q.pulseCnt + 5'h01;
            d.phase    = 2'h2;
          end
          2'h2: begin
            // Falling edge, bit still held
            d.intClk = 1'b0;
            d.phase  = 2'h0;
            d.bitCnt = q.bitCnt + 5'h01;
          end
          default: begin
            d.phase = 2'h0;
          end
        endcase
      end
    end

    // Clock edges arm the marker between reads
    if (extModeS && !q.extActive && (extRise || extFall) && (csS || orLow)) begin
      d.markArm = 1'b1;
    end

    // External readout
    if (readStart) begin
      d.extActive = 1'b1;
      d.sr        = q.heldQ;
      d.extCnt    = 5'h00;
      d.markOn    = q.markArm;
      d.markArm   = 1'b0;
      d.frame     = 1'b0;
    end else if (q.extActive) begin
      if (csS) begin
        // Select high ends the read
        d.extActive = 1'b0;
        d.frame     = 1'b0;
      end else if (extRise) begin
        d.extCnt = q.extCnt + 5'h01;
        if (q.markOn && q.extCnt == 5'h00) begin
          d.frame = 1'b1;
        end else begin
          // Output changes only after a rising edge
          d.frame = 1'b0;
          d.dataQ = q.sr[NB-1];
          d.sr    = {q.sr[NB-2:0], tagS};
          if (q.extCnt == extLast) begin
            d.extActive = 1'b0;
          end
        end
      end
    end

    // Release of the start term rearms
    if (!orLow) begin
      d.armQ = 1'b1;
    end

    // Conversion sequencer
    unique case (q.state)
      sac_pkg::ST_IDLE: begin
        if (!orLow || pdS || !q.armQ) begin
          d.startCnt = 2'h0;
        end else if (q.startCnt == 2'(sac_pkg::START_CYC - 1)) begin
          // Start held long enough
          d.state    = sac_pkg::ST_CONV;
          d.busyN    = 1'b0;
          d.armQ     = 1'b0;
          d.startCnt = 2'h0;
          d.convCnt  = 16'h0000;
          d.tagQ     = tagS;
          if (!extModeS) begin
            d.intActive = 1'b1;
            d.sr        = q.heldQ;
            d.phase     = 2'h0;
            d.bitCnt    = 5'h00;
            d.divCnt    = 8'h00;
            d.pulseCnt  = 5'h00;
          end
        end else begin
          d.startCnt = q.startCnt + 2'h1;
        end
      end
      sac_pkg::ST_CONV: begin
        // Conversion timer
        if (q.convCnt == 16'(CONV_CYC - 1)) begin
          d.state = sac_pkg::ST_DONE;
        end else begin
          d.convCnt = q.convCnt + 16'h0001;
        end
      end
      sac_pkg::ST_DONE: begin
        // Offer result; stall while the buffer is full
        if (rbuf.inReady) begin
          d.state = sac_pkg::ST_LATCH;
        end
      end
      sac_pkg::ST_LATCH: begin
        // Busy ends once the result is in the stored register
        if (popGo) begin
          d.state = sac_pkg::ST_IDLE;
          d.busyN = 1'b1;
        end
      end
      default: begin
        d.state = sac_pkg::ST_IDLE;
        d.busyN = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q       <= '0;
      q.state <= sac_pkg::ST_IDLE;
      q.busyN <= 1'b1;
      q.heldQ <= sac_pkg::HELD_RST;
    end else begin
      q <= d;
    end
  end

  // Busy falls the cycle after a start is taken
  a_busy_start: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (q.state == sac_pkg::ST_IDLE && d.state == sac_pkg::ST_CONV) |=> !busyN
  ) else $error("busy did not fall at conversion start");

  // Busy stays low while converting or latching
  a_busy_hold: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (q.state != sac_pkg::ST_IDLE) |-> !busyN
  ) else $error("busy high before result latched");

  // No start while powered down
  a_pd_block: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (pdS && q.state == sac_pkg::ST_IDLE) |=> (q.state == sac_pkg::ST_IDLE && busyN)
  ) else $error("conversion started in power-down");

  // Start needs the ORed term low for two cycles
  a_start_qual: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $fell(busyN) |-> ($past(orLow) && $past(orLow, 2))
  ) else $error("start taken without qualified strobe");

  // Busy returns only from the latch state
  a_busy_release: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $rose(busyN) |-> ($past(q.state) == sac_pkg::ST_LATCH && $past(popGo))
  ) else $error("busy released without latching");

  // Sixteen internal pulses per readout
  a_pulse_count: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $fell(q.intActive) |-> (q.pulseCnt == 5'(NB))
  ) else $error("internal pulse count wrong");

  // Internal bit steady from rise through fall
  a_bit_stable: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (q.intActive && q.intClk) |=> $stable(q.dataQ)
  ) else $error("data moved while internal clock high");

  // Tag shown after the last bit
  a_tag_after: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $fell(q.intActive) |-> (q.dataQ == q.tagQ)
  ) else $error("data is not the start tag after readout");

  // Internal clock idles low
  a_clk_idle: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !q.intActive |-> !q.intClk
  ) else $error("internal clock not low between readouts");

  // External data only moves on rising edges
  a_ext_stable: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (q.extActive && extModeS && !extRise && !readStart) |=> $stable(q.dataQ)
  ) else $error("external data changed without rising edge");

  // Marker lasts at least to the next rising edge
  a_frame_width: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (q.frame && q.extActive && !extRise && !csS) |=> q.frame
  ) else $error("frame marker shorter than one period");

  // Readout pin driven whenever internal readout runs
  a_oe_mode: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    q.intActive |-> !serialShiftClockOeN
  ) else $error("internal clock pin not driven");
endmodule

//--- rtl/sac_pkg.sv
// What this block does
// - Busy low from start until result latched
// - Power-down refuses starts, keeps stored result
// - Select and strobe ORed; either may fall first
// - Busy returns high after conversion, tracking resumes
// - First result after power-up is meaningless
// - Clock-source low internal clock, high external
// - Internal mode shifts previous result MSB first
// - Internal mode emits exactly sixteen clock pulses
// - Internal bit stable over both clock edges
// - After LSB data shows tag from start
// - Internal clock held low after sixteenth pulse
// - External mode reads previous or current result
// - Frame marker always continuous, optional when gated
// - External bit valid falling to next rising
// - Frame marker one external period at read
// - Strobe rise with select low starts read
// - Tag appears 16 or 17 periods later
package sac_pkg;
  localparam int CLK_NS      = 40;    // ref_clk period
  localparam int START_NS    = 50;    // Least start strobe width
  localparam int START_CYC   = (START_NS + CLK_NS - 1) / CLK_NS;
  localparam int RES_BITS    = 16;    // Result width
  localparam int CONV_CYC_DEF = 200;  // Default conversion length
  localparam int INT_DIV_DEF  = 4;    // Default cycles per clock phase
  localparam int FIFO_DEPTH  = 4;     // Result buffer depth
  localparam logic [15:0] HELD_RST = 16'h0000; // Stored result at reset
  // Synchroniser bit positions
  localparam int PIN_CS  = 0;
  localparam int PIN_RC  = 1;
  localparam int PIN_PD  = 2;
  localparam int PIN_EXT = 3;
  localparam int PIN_CLK = 4;
  localparam int PIN_TAG = 5;
  localparam int PIN_N   = 6;
  // Conversion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_CONV  = 4'h2,
    ST_DONE  = 4'h4,
    ST_LATCH = 4'h8
  } sac_conv_type;
endpackage

//--- rtl/sac_fifo_if.sv
`timescale 1ns/10ps
// Result path between sequencer and buffer
interface sac_fifo_if #(
  parameter int WIDTH = 16
);
  logic             inValid;  // Result offered
  logic             inReady;  // Buffer can take it
  logic [WIDTH-1:0] inData;   // Result word
  logic             outValid; // Word available
  logic             outReady; // Shifter can take it
  logic [WIDTH-1:0] outData;  // Oldest word
  modport fill (output inValid, inData, outReady, input inReady, outValid, outData);
  modport store (input inValid, inData, outReady, output inReady, outValid, outData);
endinterface

//--- rtl/sac_fifo.sv
`timescale 1ns/10ps
// Small result buffer in flip-flops
module sac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  sac_fifo_if.store port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
    logic [AW-1:0]               wr;  // Write index
    logic [AW-1:0]               rd;  // Read index
    logic [AW:0]                 cnt; // Fill level
  } sac_fifo_state_type;
  sac_fifo_state_type q;
  sac_fifo_state_type d;
  logic push;
  logic pop;
  // Honest flags from the fill level
  assign port.inReady  = (q.cnt != (AW+1)'(DEPTH));
  assign port.outValid = (q.cnt != '0);
  assign port.outData  = q.mem[q.rd];
  assign push = port.inValid && port.inReady;
  assign pop  = port.outValid && port.outReady;
  // Next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = port.inData;
      d.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
    end
    // Both at once keep the level
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end
  // State register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

//--- sim/sac_host_model.sv
`timescale 1ns/10ps
// Host side: starts conversions, drives a gated clock, captures results
module sac_host_model (
  input  wire logic ref_clk,
  input  wire logic busyN,
  input  wire logic serialData,
  input  wire logic frameMarker,
  input  wire logic clkPin,
  output logic      selectN,
  output logic      readConvert,
  output logic      hostClk
);
  logic [15:0] intWord;    // Bits caught on shift clock rises
  int          intCnt;     // Shift clock rises seen
  int          intBad;     // Bits that moved between rise and fall
  logic        pinQ;       // Pin level one cycle back
  logic        lastBit;    // Bit caught at the last rise
  logic        datF[1:18]; // Data at each host clock fall
  logic        datR[1:18]; // Data just before the next rise
  logic        mrkF[1:18]; // Marker at each host clock fall

  // Idle levels: pins released, clock parked low
  initial begin
    selectN = 1'b1;
    readConvert = 1'b1;
    hostClk = 1'b0;
    intWord = 16'h0000;
    intCnt = 0;
    intBad = 0;
    pinQ = 1'b0;
    lastBit = 1'b0;
  end

  // Watch the shift clock pin, capture on rises, check on falls
  always @(posedge ref_clk) begin
    pinQ <= clkPin;
    if (clkPin && !pinQ) begin
      intWord <= {intWord[14:0], serialData};
      intCnt  <= intCnt + 1;
      lastBit <= serialData;
    end
    if (!clkPin && pinQ && serialData !== lastBit) begin
      intBad <= intBad + 1;
    end
  end

  // Lower both start pins in the chosen order, hold them, wait for busy
  task automatic start(input bit csFirst, output int lat);
    @(negedge ref_clk);
    if (csFirst) begin
      selectN = 1'b0;
    end else begin
      readConvert = 1'b0;
    end
    @(negedge ref_clk);
    selectN = 1'b0;
    readConvert = 1'b0;
    repeat (2) @(negedge ref_clk);
    lat = 0;
    while (busyN !== 1'b0 && lat < 20) begin
      @(negedge ref_clk);
      lat++;
    end
  endtask

  // Set both control pins at one falling edge
  task automatic pins(input logic cs, input logic rc);
    @(negedge ref_clk);
    selectN = cs;
    readConvert = rc;
  endtask

  // Gated clock idling low, 320 ns period, sampled on both halves
  task automatic pulses(input int n);
    for (int k = 1; k <= n; k++) begin
      @(negedge ref_clk);
      hostClk = 1'b1;
      repeat (4) @(negedge ref_clk);
      datF[k] = serialData;
      mrkF[k] = frameMarker;
      hostClk = 1'b0;
      repeat (3) @(negedge ref_clk);
      datR[k] = serialData;
    end
  endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/10ps
// Counted comparison; four-state mismatch is reported at once
`define CHK(g, e, m) begin \
  compares++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("MISMATCH t=%0t %s", $time, m); \
  end \
end
// Self-checking bench for conversion control and serial readout
module tb_top;
  localparam int CONV = 60; // Shortened conversion length
  logic        ref_clk;             // 25 MHz clock
  logic        nrst;                // Synchronous reset
  logic        powerDownInput;      // Start inhibit
  logic        clockSourceSelect;   // Internal or external clock
  logic        chainTag;            // Daisy tag
  logic [15:0] sampleCode;          // Converter result
  logic        selectN;             // From host
  logic        readConvert;         // From host
  logic        hostClk;             // Host clock drive
  wire         clkPin;              // Resolved shift clock pin
  logic        busyN;               // Design outputs
  logic        serialData;
  logic        serialShiftClockOut;
  logic        serialShiftClockOeN;
  logic        frameMarker;
  int          miscompares;         // Failed comparisons
  int          compares;            // All comparisons
  int          lat;                 // Start to busy latency
  logic [31:0] rnd;                 // Random state
  logic [15:0] prevCode;            // Last result stored

  // Pin level: device drives when its enable is low, else host
  assign clkPin = serialShiftClockOeN ? hostClk : serialShiftClockOut;

  // Clock
  always #20 ref_clk = ~ref_clk;

  sac_adc_top #(
    .CONV_CYC (CONV),
    .INT_DIV  (1),
    .DEPTH    (sac_pkg::FIFO_DEPTH)
  ) u_dut (
    .ref_clk             (ref_clk),
    .nrst                (nrst),
    .selectN             (selectN),
    .readConvert         (readConvert),
    .powerDownInput      (powerDownInput),
    .clockSourceSelect   (clockSourceSelect),
    .serialShiftClockIn  (clkPin),
    .chainTag            (chainTag),
    .sampleCode          (sampleCode),
    .busyN               (busyN),
    .serialData          (serialData),
    .serialShiftClockOut (serialShiftClockOut),
    .serialShiftClockOeN (serialShiftClockOeN),
    .frameMarker         (frameMarker)
  );

  sac_host_model u_host (
    .ref_clk     (ref_clk),
    .busyN       (busyN),
    .serialData  (serialData),
    .frameMarker (frameMarker),
    .clkPin      (clkPin),
    .selectN     (selectN),
    .readConvert (readConvert),
    .hostClk     (hostClk)
  );

  // Next value of the random sequence
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Bit expected after read rise k, MSB first
  function automatic logic expBit(input logic [15:0] code, input int k);
    return code[16-k];
  endfunction

  // New random code and tag, driven off the sampling edge
  task automatic new_sample;
    rnd = lfsr(rnd);
    @(negedge ref_clk);
    sampleCode = rnd[15:0];
    chainTag = rnd[16];
  endtask

  // Bounded wait for busy to return high, counting low cycles
  task automatic wait_idle(output int n);
    n = 0;
    while (busyN === 1'b0 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // Internal-clock conversion; readout carries the previous result
  task automatic conv_int(input bit check);
    int n;
    int c0;
    int b0;
    new_sample();
    c0 = u_host.intCnt;
    b0 = u_host.intBad;
    u_host.start(rnd[17], lat);
    `CHK(lat < 8, 1'b1, "busy late")
    u_host.pins(1'b1, 1'b1);
    wait_idle(n);
    `CHK(n > CONV - 2, 1'b1, "busy short")
    `CHK(n < 600, 1'b1, "busy stuck")
    `CHK(u_host.intCnt - c0 == 16, 1'b1, "pulse count")
    `CHK(u_host.intBad == b0, 1'b1, "bit moved")
    `CHK(serialData, chainTag, "tag after lsb")
    `CHK(serialShiftClockOut, 1'b0, "clock not parked")
    if (check) begin
      `CHK(u_host.intWord, prevCode, "internal word")
    end
    prevCode = sampleCode;
  endtask

  // External read: after conversion, or during it with the marker armed
  task automatic conv_ext(input bit withMark);
    int n;
    int off;
    logic [15:0] exp;
    new_sample();
    exp = withMark ? prevCode : sampleCode;
    off = withMark ? 1 : 0;
    if (withMark) begin
      u_host.pulses(1);
    end
    u_host.start(1'b0, lat);
    `CHK(lat < 8, 1'b1, "busy late")
    if (!withMark) begin
      u_host.pins(1'b1, 1'b0);
      u_host.pins(1'b1, 1'b1);
      wait_idle(n);
      u_host.pins(1'b0, 1'b1);
    end else begin
      u_host.pins(1'b0, 1'b1);
    end
    repeat (4) @(negedge ref_clk);
    u_host.pulses(17 + off);
    for (int k = 1; k <= 16; k++) begin
      `CHK(u_host.datF[k+off], expBit(exp, k), "ext bit")
    end
    for (int k = 1; k <= 17 + off; k++) begin
      `CHK(u_host.datR[k], u_host.datF[k], "ext bit window")
    end
    `CHK(u_host.datF[17+off], chainTag, "ext tag")
    `CHK(u_host.mrkF[1], withMark, "marker")
    `CHK(u_host.mrkF[2], 1'b0, "marker width")
    u_host.pins(1'b1, 1'b1);
    wait_idle(n);
    prevCode = sampleCode;
  endtask

  // Verdict and end of run
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    powerDownInput = 1'b0;
    clockSourceSelect = 1'b0;
    chainTag = 1'b0;
    sampleCode = 16'h0000;
    miscompares = 0;
    compares = 0;
    rnd = 32'h24209477;
    prevCode = 16'h0000;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    `CHK(busyN, 1'b1, "reset busy")
    `CHK(serialShiftClockOut, 1'b0, "reset clock")
    `CHK(frameMarker, 1'b0, "reset marker")
    $display("Test reset done");
    repeat (4) @(negedge ref_clk);
    `CHK(serialShiftClockOeN, 1'b0, "internal enable")
    conv_int(1'b0);
    for (int i = 0; i < 4; i++) begin
      conv_int(1'b1);
    end
    $display("Test internal readout done");
    @(negedge ref_clk);
    powerDownInput = 1'b1;
    repeat (4) @(negedge ref_clk);
    u_host.start(1'b1, lat);
    `CHK(busyN, 1'b1, "start in power-down")
    u_host.pins(1'b1, 1'b1);
    powerDownInput = 1'b0;
    repeat (4) @(negedge ref_clk);
    conv_int(1'b1);
    $display("Test power-down done");
    clockSourceSelect = 1'b1;
    repeat (4) @(negedge ref_clk);
    `CHK(serialShiftClockOeN, 1'b1, "external enable")
    conv_ext(1'b0);
    conv_ext(1'b1);
    $display("Test external readout done");
    final_report();
  end
endmodule
